// ==== hw/ssp_defs.vh ====
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH

// ************************************************************
// Clock rate
// ************************************************************
`define SSP_CLK_MHZ 50

// ************************************************************
// Frame layout
// ************************************************************
`define SSP_ADDR_W 7
`define SSP_DATA_W 8
`define SSP_ADDR_BITS 8
`define SSP_XFER_BITS 16

// ************************************************************
// Pin idle levels, used as synchroniser reset values
// ************************************************************
`define SSP_SCLK_IDLE 1'b1
`define SSP_SDIO_IDLE 1'b1
`define SSP_PD_IDLE 1'b0

// ************************************************************
// Register map
// ************************************************************
`define SSP_ADDR_PART_IDENTITY 7'h00
// Arbitrary identity value, not tied to any real part
`define SSP_PART_IDENTITY_VAL 8'h5a
`define SSP_REG_COUNT 4
`define SSP_REG_RESET 8'h00

// ************************************************************
// Timing
// ************************************************************
`define SSP_PD_HOLD_US 100
`define SSP_PD_HOLD_CYC (`SSP_PD_HOLD_US * `SSP_CLK_MHZ)
`define SSP_PORT_TIMEOUT_MS 900
`define SSP_PORT_TIMEOUT_CYC (`SSP_PORT_TIMEOUT_MS * 1000 * `SSP_CLK_MHZ)

`endif

// ==== hw/ssp_port.v ====
// Notes on behaviour
// - Two-byte frame: direction bit, seven address bits, data byte; sampled on rising edges.
// - A power-down pulse after 4 ms from supply valid synchronises the port.
// - After a write the data pin stays an input, high impedance.
// - After a read the last data bit is driven until the next falling edge.
// - Power-down held 100 us forces the data line to high impedance.
// - Power-down pulse resets the serial port but keeps register contents.
// - Port resets when sixteenth rise comes over 0.9 s after the first edge.
// - Writes to unimplemented addresses ignored; reads from them return zero.
// - Device drives the data line only after the last address rising edge.
// - Device releases the line within 120 ns of the falling edge after last bit.
// - Raising power-down aborts: no register write, only the serial port resets.
// - After power-up any rising edge starts a frame; sampled bit sets direction.
`timescale 1ns/1ps
`include "ssp_defs.vh"

module ssp_port #(
    parameter PD_HOLD_CYC = `SSP_PD_HOLD_CYC,
    parameter TIMEOUT_CYC = `SSP_PORT_TIMEOUT_CYC,
    parameter REG_COUNT = `SSP_REG_COUNT
) (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // Serial link pins
    input wire sclk_i,
    input wire sdio_i,
    output reg sdio_o,
    output reg sdio_oe_o,
    input wire power_down_pin_i,
    // Status towards the rest of the device
    output reg shut_down_o,
    output reg port_busy_o,
    output reg timeout_o,
    // Register write notice
    output reg wr_strobe_o,
    output reg [6:0] wr_addr_o,
    output reg [7:0] wr_data_o
);

    // ************************************************************
    // Local constants
    // ************************************************************
    localparam PD_W = $clog2(PD_HOLD_CYC + 1);
    localparam TO_W = $clog2(TIMEOUT_CYC + 1);
    localparam integer PD_HOLD_INT = PD_HOLD_CYC;
    localparam integer TIMEOUT_INT = TIMEOUT_CYC;
    localparam integer ADDR_BITS_INT = `SSP_ADDR_BITS;
    localparam integer XFER_BITS_INT = `SSP_XFER_BITS;
    localparam [PD_W-1:0] PD_LIMIT = PD_HOLD_INT[PD_W-1:0];
    localparam [TO_W-1:0] TO_LIMIT = TIMEOUT_INT[TO_W-1:0];
    localparam [4:0] LAST_ADDR_CNT = ADDR_BITS_INT[4:0] - 5'h01;
    localparam [4:0] LAST_BIT_CNT = XFER_BITS_INT[4:0] - 5'h01;

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_WDATA = 3'h2;
    localparam [2:0] ST_RDATA = 3'h3;
    localparam [2:0] ST_RHOLD = 3'h4;

    // ************************************************************
    // Pin synchronisation and edge detection
    // ************************************************************
    wire sclk_s;
    wire sdio_s;
    wire pd_s;
    reg sclk_d;
    wire sclk_rise;
    wire sclk_fall;

    // Reset to each pin's idle level, so leaving reset shows no false clock edge
    ssp_sync #(
        .WIDTH(1),
        .RST_VAL(`SSP_SCLK_IDLE)
    ) u_sync_sclk (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(sclk_i),
        .sync_o(sclk_s)
    );

    ssp_sync #(
        .WIDTH(1),
        .RST_VAL(`SSP_SDIO_IDLE)
    ) u_sync_sdio (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(sdio_i),
        .sync_o(sdio_s)
    );

    ssp_sync #(
        .WIDTH(1),
        .RST_VAL(`SSP_PD_IDLE)
    ) u_sync_pd (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(power_down_pin_i),
        .sync_o(pd_s)
    );

    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            sclk_d <= `SSP_SCLK_IDLE;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    // ************************************************************
    // Power-down hold timer
    // ************************************************************
    // The port aborts at once on power-down; the line release and shut_down_o both wait out the hold
    reg [PD_W-1:0] pd_cnt;
    reg pd_long;

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            pd_cnt <= {PD_W{1'b0}};
            pd_long <= 1'b0;
            shut_down_o <= 1'b0;
        end else begin
            if (!pd_s) begin
                pd_cnt <= {PD_W{1'b0}};
                pd_long <= 1'b0;
            end else if (pd_cnt != PD_LIMIT) begin
                pd_cnt <= pd_cnt + 1'b1;
            end else begin
                pd_long <= 1'b1;
            end
            shut_down_o <= pd_long;
        end
    end

    // ************************************************************
    // Register store
    // ************************************************************
    reg [6:0] addr_sr;
    wire [6:0] next_addr;
    wire [7:0] rd_data;

    assign next_addr = {addr_sr[5:0], sdio_s};

    ssp_regs #(
        .REG_COUNT(REG_COUNT)
    ) u_regs (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(wr_strobe_o),
        .wr_addr_i(wr_addr_o),
        .wr_data_i(wr_data_o),
        .rd_addr_i(next_addr),
        .rd_data_o(rd_data)
    );

    // ************************************************************
    // Transaction timer
    // ************************************************************
    reg [2:0] state;
    reg [TO_W-1:0] to_cnt;
    wire counting;
    wire to_hit;

    // Stopped in the read hold phase, where the port waits on the host clock
    assign counting = (state == ST_ADDR) || (state == ST_WDATA) || (state == ST_RDATA);
    assign to_hit = counting && (to_cnt == TO_LIMIT);

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            to_cnt <= {TO_W{1'b0}};
        end else if (state == ST_IDLE || pd_s) begin
            to_cnt <= {TO_W{1'b0}};
        end else if (counting && !to_hit) begin
            to_cnt <= to_cnt + 1'b1;
        end
    end

    // ************************************************************
    // Serial port state machine
    // ************************************************************
    reg [4:0] bit_cnt;
    reg dir_write;
    reg [7:0] data_sr;

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
            bit_cnt <= 5'h00;
            dir_write <= 1'b0;
            addr_sr <= 7'h00;
            data_sr <= 8'h00;
            sdio_o <= 1'b0;
            sdio_oe_o <= 1'b0;
            port_busy_o <= 1'b0;
            timeout_o <= 1'b0;
            wr_strobe_o <= 1'b0;
            wr_addr_o <= 7'h00;
            wr_data_o <= 8'h00;
        end else begin
            wr_strobe_o <= 1'b0;
            timeout_o <= 1'b0;
            port_busy_o <= (state != ST_IDLE);
            if (pd_s) begin
                // Abort: port state cleared, registers untouched
                state <= ST_IDLE;
                bit_cnt <= 5'h00;
                dir_write <= 1'b0;
                if (pd_long) begin
                    sdio_oe_o <= 1'b0;
                end
            end else if (to_hit) begin
                state <= ST_IDLE;
                bit_cnt <= 5'h00;
                dir_write <= 1'b0;
                sdio_oe_o <= 1'b0;
                timeout_o <= 1'b1;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (sclk_rise) begin
                            dir_write <= sdio_s;
                            bit_cnt <= 5'h01;
                            state <= ST_ADDR;
                        end else if (sclk_fall) begin
                            // A read cut off by a short power-down pulse lets go here
                            sdio_oe_o <= 1'b0;
                        end
                    end
                    ST_ADDR: begin
                        if (sclk_rise) begin
                            addr_sr <= next_addr;
                            bit_cnt <= bit_cnt + 5'h01;
                            if (bit_cnt == LAST_ADDR_CNT) begin
                                if (dir_write) begin
                                    state <= ST_WDATA;
                                end else begin
                                    // Unmapped addresses read back as zero
                                    data_sr <= rd_data;
                                    state <= ST_RDATA;
                                end
                            end
                        end
                    end
                    ST_WDATA: begin
                        if (sclk_rise) begin
                            data_sr <= {data_sr[6:0], sdio_s};
                            bit_cnt <= bit_cnt + 5'h01;
                            if (bit_cnt == LAST_BIT_CNT) begin
                                // Store ignores unmapped targets; pin stays input
                                wr_strobe_o <= 1'b1;
                                wr_addr_o <= addr_sr;
                                wr_data_o <= {data_sr[6:0], sdio_s};
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (sclk_fall) begin
                            // Driving starts only after the last address rise
                            sdio_oe_o <= 1'b1;
                            sdio_o <= data_sr[7];
                            data_sr <= {data_sr[6:0], 1'b0};
                        end else if (sclk_rise) begin
                            bit_cnt <= bit_cnt + 5'h01;
                            if (bit_cnt == LAST_BIT_CNT) begin
                                state <= ST_RHOLD;
                            end
                        end
                    end
                    ST_RHOLD: begin
                        if (sclk_fall) begin
                            sdio_oe_o <= 1'b0;
                            bit_cnt <= 5'h00;
                            dir_write <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                        bit_cnt <= 5'h00;
                        sdio_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

// ==== hw/ssp_regs.v ====
`timescale 1ns/1ps
`include "ssp_defs.vh"

// ************************************************************
// Register store behind the serial port
// ************************************************************
module ssp_regs #(
    parameter REG_COUNT = `SSP_REG_COUNT,
    parameter [7:0] IDENTITY = `SSP_PART_IDENTITY_VAL
) (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // Write side
    input wire wr_en_i,
    input wire [6:0] wr_addr_i,
    input wire [7:0] wr_data_i,
    // Read side
    input wire [6:0] rd_addr_i,
    output reg [7:0] rd_data_o
);

    reg [7:0] mem [1:REG_COUNT-1];
    integer i;

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (i = 1; i < REG_COUNT; i = i + 1) begin
                mem[i] <= `SSP_REG_RESET;
            end
        end else if (wr_en_i && wr_addr_i != `SSP_ADDR_PART_IDENTITY &&
                     wr_addr_i < REG_COUNT) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always @* begin
        if (rd_addr_i == `SSP_ADDR_PART_IDENTITY) begin
            rd_data_o = IDENTITY;
        end else if (rd_addr_i < REG_COUNT) begin
            rd_data_o = mem[rd_addr_i];
        end else begin
            rd_data_o = 8'h00;
        end
    end

endmodule

// ==== hw/ssp_sync.v ====
`timescale 1ns/1ps

// ************************************************************
// Two-stage synchroniser for pins from outside the clock domain
// ************************************************************
module ssp_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // Asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta;

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end

endmodule

// ==== tb/ssp_host.sv ====
`timescale 1ns/1ps
// ****
// Host side of the serial link
// ****
module ssp_host #(
    parameter GAP = 5000
) (
    // Clock and line level
    input wire logic clk_i,
    input wire logic line_i,
    // Pins towards the device
    output logic sclk_o = 1'b1,
    output logic sd_o = 1'b1,
    output logic sd_oe_o = 1'b1,
    output logic pd_o = 1'b0,
    // Read result
    output logic rv_o = 1'b0,
    output logic [7:0] rd_o = 8'h00
);
    logic wr_last = 1'b0;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic pd_set(input logic b, input int n);
        pd_o <= b;
        tick(n);
    endtask
    // Frame of n bits, data changed after falls
    task automatic frame(input logic wr, input logic [6:0] a, input logic [7:0] d, input int n);
        logic [15:0] sh;
        sh = {wr, a, d};
        tick(wr_last ? GAP : 2);
        for (int i = 0; i < n; i++) begin
            sclk_o <= 1'b0;
            if (i == 0)
                tick(5);
            if (i < 8 || wr) begin
                sd_o <= sh[15-i];
                sd_oe_o <= 1'b1;
            end
            tick(i == 0 ? 1 : 4);
            sclk_o <= 1'b1;
            tick(1);
            if (i >= 8 && !wr)
                rd_o <= {rd_o[6:0], line_i};
            if (i == 7 && !wr) begin
                sd_oe_o <= 1'b0;
                tick(GAP);
            end else
                tick(3);
        end
        if (!wr && n == 16) begin
            rv_o <= 1'b1;
            tick(1);
            rv_o <= 1'b0;
        end
        wr_last = wr;
    endtask
endmodule

// ==== tb/ssp_port_sva.sv ====
`timescale 1ns/1ps
// ****
// Port checker
// ****
module ssp_port_sva #(
    parameter PD_HOLD_CYC = 20
) (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // Link
    input wire sclk_i,
    input wire sdio_i,
    input wire sdio_o,
    input wire sdio_oe_o,
    input wire power_down_pin_i,
    // Status and write notice
    input wire shut_down_o,
    input wire port_busy_o,
    input wire timeout_o,
    input wire wr_strobe_o,
    input wire [6:0] wr_addr_o,
    input wire [7:0] wr_data_o
);
    int pdc;
    always @(posedge clk_i) begin
        if (sys_rst_i || !power_down_pin_i)
            pdc <= 0;
        else if (pdc < 1000)
            pdc <= pdc + 1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    pd_nowr_a: assert property (power_down_pin_i [*8] |-> !wr_strobe_o)
        else $error("write while powered down");
    pd_hiz_a: assert property (pdc > PD_HOLD_CYC + 4 |-> !sdio_oe_o && shut_down_o)
        else $error("line driven in shutdown");
    wr_hold_a: assert property (!wr_strobe_o |-> $stable(wr_addr_o) && $stable(wr_data_o))
        else $error("write notice moved");
    sd_stable_a: assert property (sdio_oe_o && $past(sdio_oe_o) && sclk_i && $past(sclk_i)
        && $past(sclk_i, 2) |-> $stable(sdio_o))
        else $error("data changed while clock high");
    hold_bit_a: assert property (sclk_i [*6] ##0 (sdio_oe_o && !power_down_pin_i) |=> sdio_oe_o)
        else $error("last bit not held");
    wr_hiz_a: assert property (wr_strobe_o |-> !sdio_oe_o [*8])
        else $error("line driven after write");
    drop_fall_a: assert property ($fell(sdio_oe_o) |-> (!sclk_i || timeout_o || $past(timeout_o))
        or ##[0:1] shut_down_o)
        else $error("line released off a fall");
    tmo_reset_a: assert property (timeout_o |-> $past(port_busy_o) ##1 !timeout_o ##[0:2] !port_busy_o)
        else $error("timeout pulse wrong");
    frame_start_a: assert property (!power_down_pin_i [*4] ##0 !port_busy_o ##0 $rose(sclk_i)
        |-> ##[2:6] port_busy_o)
        else $error("rise did not start frame");
    cover property (wr_strobe_o);
    cover property (timeout_o);
    cover property (shut_down_o);
    cover property ($rose(sdio_oe_o));
endmodule

// ==== tb/ssp_port_tb.sv ====
`timescale 1ns/1ps
`include "ssp_defs.vh"
module ssp_port_tb;
    localparam int PDH = 20;
    localparam int TMO = 6000;
    localparam logic [7:0] ID = `SSP_PART_IDENTITY_VAL;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic flt = 1'b0;
    logic sclk, hd, hoe, pd, rv, line;
    logic [7:0] rd;
    logic sdio_o, sdio_oe_o, shut_down_o, port_busy_o, timeout_o, wr_strobe_o;
    logic [6:0] wr_addr_o;
    logic [7:0] wr_data_o;
    logic [16:0] exp_q[$];
    logic [16:0] lf = 17'd84294;
    logic [7:0] v [1:3];
    int err_count = 0;
    int tests_run = 0;
    always #10 clk_i = ~clk_i;
    // Released line wanders so a stale level never passes
    always @(posedge clk_i) flt <= ~flt;
    assign line = sdio_oe_o ? sdio_o : (hoe ? hd : flt);
    ssp_port #(.PD_HOLD_CYC(PDH), .TIMEOUT_CYC(TMO)) i_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .sdio_i(line),
        .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .power_down_pin_i(pd),
        .shut_down_o(shut_down_o), .port_busy_o(port_busy_o), .timeout_o(timeout_o),
        .wr_strobe_o(wr_strobe_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));
    ssp_host i_host (
        .clk_i(clk_i), .line_i(line), .sclk_o(sclk), .sd_o(hd), .sd_oe_o(hoe),
        .pd_o(pd), .rv_o(rv), .rd_o(rd));
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic take(input logic [16:0] g);
        logic [16:0] e;
        e = exp_q.size() ? exp_q.pop_front() : 17'h1ffff;
        chk("result", e, g);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        exp_q.push_back({2'd1, a, d});
        i_host.frame(1'b1, a, d, 16);
    endtask
    task automatic rdx(input logic [6:0] a, input logic [7:0] d);
        exp_q.push_back({9'h100, d});
        i_host.frame(1'b0, a, 8'h00, 16);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (wr_strobe_o === 1'b1)
            take({2'd1, wr_addr_o, wr_data_o});
        if (timeout_o === 1'b1)
            take(17'h18000);
        if (rv === 1'b1)
            take({9'h100, rd});
    end
    initial begin
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        i_host.tick(TMO + 10);
        rdx(7'h00, ID);
        for (int a = 1; a < 4; a++) begin
            lf = lfsr(lf);
            v[a] = lf[7:0];
            wr(a[6:0], v[a]);
        end
        wr(7'h05, 8'h3c);
        wr(7'h00, 8'hff);
        for (int a = 1; a < 4; a++)
            rdx(a[6:0], v[a]);
        rdx(7'h05, 8'h00);
        rdx(7'h00, ID);
        i_host.frame(1'b1, 7'h01, ~v[1], 12);
        i_host.pd_set(1'b1, PDH + 10);
        i_host.pd_set(1'b0, 10);
        rdx(7'h01, v[1]);
        i_host.tick(20);
        chk("hold", {15'd0, 1'b1, v[1][0]}, {15'd0, sdio_oe_o, sdio_o});
        i_host.pd_set(1'b1, PDH + 10);
        chk("pd_oe", 17'd0, {16'd0, sdio_oe_o});
        chk("shut", 17'd1, {16'd0, shut_down_o});
        i_host.pd_set(1'b0, 10);
        rdx(7'h00, ID);
        exp_q.push_back(17'h18000);
        i_host.frame(1'b0, 7'h00, 8'h00, 5);
        i_host.tick(TMO + 50);
        rdx(7'h00, ID);
        i_host.tick(20);
        chk("pending", 17'd0, 17'(exp_q.size()));
        test_done();
    end
    initial begin
        i_host.tick(97000);
        err_count++;
        test_done();
    end
endmodule
bind ssp_port ssp_port_sva #(.PD_HOLD_CYC(PD_HOLD_CYC)) i_sva (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i), .sdio_i(sdio_i),
    .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .power_down_pin_i(power_down_pin_i),
    .shut_down_o(shut_down_o), .port_busy_o(port_busy_o), .timeout_o(timeout_o),
    .wr_strobe_o(wr_strobe_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));
